// ==== asp_pkg.sv ====
package asp_pkg;
    // Register location and layout
    localparam logic [6:0] ASP_ADDR = 7'h03;
    localparam int ASP_BIT_PG_RSV = 7;
    localparam int ASP_BIT_PG_HI = 6;
    localparam int ASP_BIT_PG_LO = 5;
    localparam int ASP_BIT_WDX = 4;
    localparam int ASP_BIT_SLP = 3;
    localparam int ASP_BIT_Z = 2;
    localparam int ASP_BIT_DC = 1;
    localparam int ASP_BIT_C = 0;
    // Power-on values
    localparam logic [2:0] ASP_PAGE_RST = 3'h0;
    localparam logic ASP_WDX_RST = 1'b1;
    localparam logic ASP_SLP_RST = 1'b1;
    localparam logic [2:0] ASP_ALU_RST = 3'h0;
    // Paging
    localparam int ASP_PAGE_WORDS = 512;
    localparam int ASP_PC_W = 11;
    // Flag update kinds from the execution logic
    typedef enum logic [2:0] {
        ASP_OP_NONE = 3'b000,
        ASP_OP_ADD = 3'b001,
        ASP_OP_SUB = 3'b010,
        ASP_OP_RRF = 3'b011,
        ASP_OP_RLF = 3'b100,
        ASP_OP_LOGIC = 3'b101
    } asp_op_t;
endpackage

// ==== asp_status_reg.sv ====
`timescale 1ns/1ps
// Function
// - Register accepts writes from any instruction; writable bits store normally.
// - Flag-updating instruction blocks data write to zero, nibble, carry flags.
// - Software writes to watchdog-expiry and sleep-entered flags are ignored.
// - Clear-file on register zeroes page bits, sets zero flag, keeps others.
// - Address 03h; bits 7-5 page, 4 watchdog, 3 sleep, 2-0 ALU flags.
// - Power-on: page bits 0, reset-cause flags 1, ALU flags 0.
// - Page code selects one of four 512-word program pages.
// - Each selected page spans 512 instruction words.
// - Watchdog flag set by power-up, clear-watchdog, sleep; cleared on timeout.
// - Add: nibble flag is carry out of bit 3.
// - Subtract: nibble flag is one when no borrow from bit 3.
// - Carry flag: add carry out; subtract one means no borrow.
// - Rotates load carry flag with bit shifted out.
// - Page bits supply PC bits 9 and 10 on jumps, calls, PC writes.
// - Every reset clears page bits; sequential increment never updates them.
module asp_status_reg
    import asp_pkg::*;
#(
    parameter int PC_W = ASP_PC_W
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Reset cause: high for power-on, low for external or watchdog reset
    input wire logic por_i,
    // File write port
    input wire logic wr_en_i,
    input wire logic [6:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic clrf_i,
    // ALU flag update
    input wire logic [2:0] alu_op_i,
    input wire logic [7:0] alu_a_i,
    input wire logic [7:0] alu_b_i,
    input wire logic [7:0] alu_res_i,
    input wire logic alu_z_upd_i,
    // Power management events
    input wire logic clrwdt_i,
    input wire logic sleep_i,
    input wire logic wdt_timeout_i,
    // Program counter branch load
    input wire logic branch_i,
    input wire logic [8:0] branch_lo_i,
    // Outputs
    output logic [7:0] status_o,
    output logic [PC_W-1:0] branch_pc_o
);
    // ========================================
    // Operation decode
    asp_op_t op;
    logic is_add;
    logic is_sub;
    logic is_rrf;
    logic is_rlf;
    logic is_logic;
    logic hit;
    logic z_upd;
    logic dc_upd;
    logic c_upd;
    logic flags_locked;

    // Matches the incoming operation code
    function automatic logic op_is(input asp_op_t kind, input asp_op_t want);
        op_is = (kind == want);
    endfunction

    assign op = asp_op_t'(alu_op_i);
    assign is_add = op_is(op, ASP_OP_ADD);
    assign is_sub = op_is(op, ASP_OP_SUB);
    assign is_rrf = op_is(op, ASP_OP_RRF);
    assign is_rlf = op_is(op, ASP_OP_RLF);
    assign is_logic = op_is(op, ASP_OP_LOGIC);
    assign hit = wr_en_i && (wr_addr_i == ASP_ADDR);
    assign z_upd = alu_z_upd_i || is_add || is_sub || is_logic;
    assign dc_upd = is_add || is_sub;
    assign c_upd = is_add || is_sub || is_rrf || is_rlf;
    // Clear-file counts as a zero-flag instruction
    assign flags_locked = z_upd || dc_upd || c_upd || clrf_i;

    // ========================================
    // Arithmetic flag values
    logic [4:0] nib_sum;
    logic [8:0] byte_sum;
    logic [4:0] nib_dif;
    logic [8:0] byte_dif;
    logic z_val;
    logic dc_val;
    logic c_val;
    logic rot_out;

    assign nib_sum = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]};
    assign byte_sum = {1'b0, alu_a_i} + {1'b0, alu_b_i};
    // File minus W: a is file, b is W; top bit set means borrow
    assign nib_dif = {1'b0, alu_a_i[3:0]} - {1'b0, alu_b_i[3:0]};
    assign byte_dif = {1'b0, alu_a_i} - {1'b0, alu_b_i};
    assign z_val = (alu_res_i == 8'h00);
    assign dc_val = is_add ? nib_sum[4] : ~nib_dif[4];
    assign rot_out = is_rrf ? alu_a_i[0] : alu_a_i[7];
    assign c_val = is_add ? byte_sum[8] :
                   is_sub ? ~byte_dif[8] : rot_out;

    // ========================================
    // Software write path
    logic [7:0] wr_val;
    logic page_wr;
    logic alu_wr;

    // Clear-file writes zero
    assign wr_val = clrf_i ? 8'h00 : wr_data_i;
    assign page_wr = hit;
    assign alu_wr = hit && !flags_locked;

    // ========================================
    // Field next values
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [2:0] page_d;
    logic wdx_d;
    logic slp_d;
    logic z_d;
    logic dc_d;
    logic c_d;

    // Page bits take data only
    assign page_d = page_wr ? wr_val[ASP_BIT_PG_RSV:ASP_BIT_PG_LO]
                            : status_q[ASP_BIT_PG_RSV:ASP_BIT_PG_LO];

    // Zero flag: clear-file wins, then the result, then data
    always_comb begin
        z_d = status_q[ASP_BIT_Z];
        if (clrf_i && hit) begin
            z_d = 1'b1;
        end else if (z_upd) begin
            z_d = z_val;
        end else if (alu_wr) begin
            z_d = wr_val[ASP_BIT_Z];
        end
    end

    always_comb begin
        dc_d = status_q[ASP_BIT_DC];
        if (dc_upd) begin
            dc_d = dc_val;
        end else if (alu_wr) begin
            dc_d = wr_val[ASP_BIT_DC];
        end
    end

    always_comb begin
        c_d = status_q[ASP_BIT_C];
        if (c_upd) begin
            c_d = c_val;
        end else if (alu_wr) begin
            c_d = wr_val[ASP_BIT_C];
        end
    end

    // Power management owns the reset-cause flags; data never reaches them
    // A set event and a timeout together leave the flag clear
    always_comb begin
        wdx_d = status_q[ASP_BIT_WDX];
        if (wdt_timeout_i) begin
            wdx_d = 1'b0;
        end else if (clrwdt_i || sleep_i) begin
            wdx_d = 1'b1;
        end
    end

    always_comb begin
        slp_d = status_q[ASP_BIT_SLP];
        if (sleep_i) begin
            slp_d = 1'b0;
        end else if (clrwdt_i) begin
            slp_d = 1'b1;
        end
    end

    assign status_d = {page_d, wdx_d, slp_d, z_d, dc_d, c_d};

    // ========================================
    // Branch target formation
    logic [PC_W-1:0] branch_pc_q;
    logic [PC_W-1:0] branch_pc_d;
    logic [10:0] full_pc;

    // Page field picks a 512-word page; low bits come from the instruction
    // Sequential increments never touch the page field
    assign full_pc = {status_q[ASP_BIT_PG_HI:ASP_BIT_PG_LO], branch_lo_i};
    assign branch_pc_d = branch_i ? full_pc[PC_W-1:0]
                                  : branch_pc_q;

    // ========================================
    // Registers
    // Clock enable low freezes everything but reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            // Page and ALU flags clear on every reset
            status_q[7:5] <= ASP_PAGE_RST;
            status_q[2:0] <= ASP_ALU_RST;
            // Reset-cause flags load only on power-on reset
            if (por_i) begin
                status_q[ASP_BIT_WDX] <= ASP_WDX_RST;
                status_q[ASP_BIT_SLP] <= ASP_SLP_RST;
            end
            branch_pc_q <= '0;
        end else if (clk_en_i) begin
            status_q <= status_d;
            branch_pc_q <= branch_pc_d;
        end
    end

    assign status_o = status_q;
    assign branch_pc_o = branch_pc_q;
endmodule

// ==== asp_exec_model.sv ====
`timescale 1ns/1ps
module asp_exec_model
    import asp_pkg::*;
(
    // Operation and operands
    input wire logic [2:0] op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    // Result seen by the zero flag
    output logic [7:0] res_o
);
    always_comb begin
        case (op_i)
            ASP_OP_ADD: res_o = a_i + b_i;
            ASP_OP_SUB: res_o = a_i - b_i;
            ASP_OP_LOGIC: res_o = a_i & b_i;
            default: res_o = a_i;
        endcase
    end
endmodule

// ==== asp_chk.sv ====
`timescale 1ns/1ps
module asp_chk
    import asp_pkg::*;
#(
    parameter int PC_W = ASP_PC_W
) (
    input wire logic core_clk_i, rst_i, clk_en_i, por_i, wr_en_i, clrf_i,
    input wire logic clrwdt_i, sleep_i, wdt_timeout_i, branch_i,
    input wire logic [6:0] wr_addr_i,
    input wire logic [7:0] wr_data_i, alu_a_i, alu_b_i, alu_res_i, status_o,
    input wire logic [2:0] alu_op_i,
    input wire logic [8:0] branch_lo_i,
    input wire logic [PC_W-1:0] branch_pc_o
);
    // ==========
    // Helpers
    wire logic go = clk_en_i && !rst_i;
    wire logic hit = go && wr_en_i && wr_addr_i == ASP_ADDR;
    wire logic [4:0] dsum = alu_a_i[3:0] + alu_b_i[3:0];
    wire logic [8:0] sum = alu_a_i + alu_b_i;
    wire logic is_add = alu_op_i == ASP_OP_ADD;
    wire logic [1:0] alu_f = is_add ? {dsum[4], sum[8]} :
        {alu_a_i[3:0] >= alu_b_i[3:0], alu_a_i >= alu_b_i};
    wire logic rot_c = alu_op_i == ASP_OP_RRF ? alu_a_i[0] : alu_a_i[7];
    wire logic z_op = is_add || alu_op_i inside {ASP_OP_SUB, ASP_OP_LOGIC};
    wire logic zres = alu_res_i == 8'h00;
    wire logic [PC_W-1:0] bpc = {status_o[6:5], branch_lo_i};
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    property p_por; disable iff (1'b0) rst_i && por_i |=> status_o == 8'h18;
    endproperty
    a_por: assert property (p_por) else $error("bad power-on value");
    property p_ext; disable iff (1'b0) rst_i && !por_i |=>
        status_o[7:5] == 3'h0 && $stable(status_o[4:3]); endproperty
    a_ext: assert property (p_ext) else $error("bad reset value");
    property p_ro; hit && !clrwdt_i && !sleep_i && !wdt_timeout_i |=>
        $stable(status_o[4:3]); endproperty
    a_ro: assert property (p_ro) else $error("cause flag written");
    property p_page; hit |=> status_o[7:5] ==
        ($past(clrf_i) ? 3'h0 : $past(wr_data_i[7:5])); endproperty
    a_page: assert property (p_page) else $error("page bits");
    property p_arith; go && (is_add || alu_op_i == ASP_OP_SUB) |=>
        status_o[1:0] == $past(alu_f); endproperty
    a_arith: assert property (p_arith) else $error("carry");
    property p_rot; go && alu_op_i inside {ASP_OP_RRF, ASP_OP_RLF} |=>
        status_o[0] == $past(rot_c); endproperty
    a_rot: assert property (p_rot) else $error("rotate carry");
    property p_zero; go && z_op |=> status_o[2] == $past(zres); endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_wdt; go && wdt_timeout_i |=> !status_o[4]; endproperty
    a_wdt: assert property (p_wdt) else $error("timeout flag");
    property p_bra; go && branch_i |=> branch_pc_o == $past(bpc); endproperty
    a_bra: assert property (p_bra) else $error("branch pc");
    property p_slp; go && sleep_i |=> !status_o[3]; endproperty
    a_slp: assert property (p_slp) else $error("sleep flag");
    property p_clr; hit && clrf_i && alu_op_i == ASP_OP_NONE |=>
        status_o[2:0] == {1'b1, $past(status_o[1:0])}; endproperty
    a_clr: assert property (p_clr) else $error("clear-file flags");
endmodule
bind asp_status_reg asp_chk #(.PC_W(PC_W)) asp_chk_inst (.*);

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import asp_pkg::*;
    logic core_clk_i = 0, rst_i = 1, clk_en_i = 1, por_i = 1, clrf_i = 0;
    logic wr_en_i = 0, clrwdt_i = 0, sleep_i = 0, wdt_timeout_i = 0;
    logic branch_i = 0, alu_z_upd_i = 0;
    logic [6:0] wr_addr_i = 0;
    logic [7:0] wr_data_i = 0, alu_a_i = 0, alu_b_i = 0, alu_res_i, status_o;
    logic [2:0] alu_op_i = 0;
    logic [8:0] branch_lo_i = 0;
    logic [10:0] branch_pc_o, mb = 0;
    logic [7:0] ms = 8'h18;
    int error_cnt = 0, compares = 0, cyc = 0;
    asp_status_reg asp_status_reg_inst (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .por_i(por_i),
        .wr_en_i(wr_en_i),
        .wr_addr_i(wr_addr_i),
        .wr_data_i(wr_data_i),
        .clrf_i(clrf_i),
        .alu_op_i(alu_op_i),
        .alu_a_i(alu_a_i),
        .alu_b_i(alu_b_i),
        .alu_res_i(alu_res_i),
        .alu_z_upd_i(alu_z_upd_i),
        .clrwdt_i(clrwdt_i),
        .sleep_i(sleep_i),
        .wdt_timeout_i(wdt_timeout_i),
        .branch_i(branch_i),
        .branch_lo_i(branch_lo_i),
        .status_o(status_o),
        .branch_pc_o(branch_pc_o)
    );
    asp_exec_model asp_exec_model_inst (.op_i(alu_op_i), .a_i(alu_a_i),
        .b_i(alu_b_i), .res_o(alu_res_i));
    always #2.5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (++cyc > 4000) begin
        error_cnt++;
        print_verdict();
    end
    task check(input logic [10:0] seen, input logic [10:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("Compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========
    // Random instruction and its expected effect
    task drive;
        logic [8:0] s;
        logic [4:0] d;
        rst_i = $urandom % 50 == 0;
        por_i = 1'($urandom);
        clk_en_i = rst_i || $urandom % 8 != 0;
        wr_en_i = 1'($urandom);
        wr_addr_i = $urandom % 2 ? ASP_ADDR : 7'($urandom);
        wr_data_i = 8'($urandom);
        alu_op_i = 3'($urandom % 6);
        alu_a_i = 8'($urandom);
        alu_b_i = 8'($urandom);
        clrf_i = wr_en_i && alu_op_i == 0 && $urandom % 3 == 0;
        alu_z_upd_i = !clrf_i && alu_op_i == 0 && $urandom % 4 == 0;
        {clrwdt_i, sleep_i, wdt_timeout_i} = 3'($urandom);
        branch_i = !wr_en_i && $urandom % 2;
        branch_lo_i = 9'($urandom);
        s = alu_a_i + alu_b_i;
        d = alu_a_i[3:0] + alu_b_i[3:0];
        if (rst_i) begin
            ms = {3'h0, por_i ? 2'b11 : ms[4:3], 3'h0};
            mb = 0;
        end else if (clk_en_i) begin
            if (branch_i) mb = {ms[6:5], branch_lo_i};
            if (wr_en_i && wr_addr_i == ASP_ADDR) begin
                ms[7:5] = clrf_i ? 3'h0 : wr_data_i[7:5];
                if (clrf_i) ms[2] = 1'b1;
                else if (alu_op_i == 0 && !alu_z_upd_i)
                    ms[2:0] = wr_data_i[2:0];
            end
            if (alu_z_upd_i) ms[2] = alu_a_i == 0;
            case (alu_op_i)
                ASP_OP_ADD: ms[2:0] = {s[7:0] == 0, d[4], s[8]};
                ASP_OP_SUB: ms[2:0] = {alu_a_i == alu_b_i,
                    alu_a_i[3:0] >= alu_b_i[3:0], alu_a_i >= alu_b_i};
                ASP_OP_RRF: ms[0] = alu_a_i[0];
                ASP_OP_RLF: ms[0] = alu_a_i[7];
                ASP_OP_LOGIC: ms[2] = (alu_a_i & alu_b_i) == 0;
                default: ;
            endcase
            if (clrwdt_i) ms[4:3] = 2'b11;
            if (sleep_i) ms[4:3] = 2'b10;
            if (wdt_timeout_i) ms[4] = 1'b0;
        end
    endtask
    initial begin
        void'($urandom(61));
        repeat (10) @(negedge core_clk_i);
        check(status_o, 8'h18);
        check(branch_pc_o, 0);
        $display("Test power-on reset done");
        repeat (3000) begin
            drive();
            @(negedge core_clk_i);
            check(status_o, ms);
            check(branch_pc_o, mb);
        end
        $display("Test random instruction stream done");
        print_verdict();
    end
endmodule
